// file: design/sdram_bank_cke_state.sv
// Command decode, clock-enable power states and bank array of an SDRAM
`timescale 1ns/1ns
`default_nettype none
`include "bank_state_consts.svh"

// Contract
// - Commands act only with clock enable high twice, tRC after self refresh.
// - Strobes decode to activate, read, write and precharge.
// - Deselect or no-op continues the running operation.
// - Burst stop acts only on the current burst's bank.
// - Cutting an auto-precharge burst starts that bank's precharge.
// - Idle after precharge time; active after activate delay.
// - Read or write state lasts until the burst ends or is cut.
// - Auto-precharge states last until the burst ends or is cut.
// - Clock enable sampled each edge; pair with previous sample.
// - Action from state before the edge and command at it.
// - Clock enable low twice holds low-power state, ignores commands.
// - Rising clock enable exits; power down, self refresh need no-op.
// - Falling clock enable, all idle, no-op: precharge power down.
// - Falling clock enable, open row, no-op: active power down.
// - Falling, all idle: refresh enters self refresh, stop deep power down.
// - Falling clock enable in a burst suspends until it rises.
// - Deep power down needs banks precharged; data is lost.
module sdram_bank_cke_state (
    input wire logic core_clk, // Device clock, 100 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic cke, // Clock enable pin
    input wire bank_state_pkg::cmd_pins_t cmd, // Command strobes, bank, auto precharge
    output bank_state_pkg::pwr_st_t pwr_state_q, // Global power state
    output bank_state_pkg::bank_st_t bank_state_q [`NUM_BANKS], // Per-bank state
    output logic all_idle_q, // Every bank idle
    output logic data_lost_q, // Contents lost by deep power down
    output logic cmd_ignored_q // Last command fell on an illegal slot
);

    bank_state_pkg::cmd_t dec;
    bank_state_pkg::bank_req_t req [`NUM_BANKS];
    logic cke_prev_q;
    logic [`CNT_W-1:0] gcnt_q;
    logic [`BANK_BITS-1:0] last_burst_q;
    logic [`NUM_BANKS-1:0] busy;
    logic any_open;
    logic all_idle;
    logic any_burst;
    logic normal;
    logic nop;
    logic hold;

    // Strobe decode with chip select low; deselect wins
    always_comb begin
        if (cmd.cs_n) begin
            dec = bank_state_pkg::CMD_DESELECT;
        end else begin
            case ({cmd.ras_n, cmd.cas_n, cmd.we_n})
                3'h3: dec = bank_state_pkg::CMD_ACTIVE;
                3'h5: dec = bank_state_pkg::CMD_READ;
                3'h4: dec = bank_state_pkg::CMD_WRITE;
                3'h2: dec = bank_state_pkg::CMD_PRECHARGE;
                3'h1: dec = bank_state_pkg::CMD_REFRESH;
                3'h0: dec = bank_state_pkg::CMD_MODE_SET;
                3'h6: dec = bank_state_pkg::CMD_BURST_STOP;
                default: dec = bank_state_pkg::CMD_NOP;
            endcase
        end
    end

    assign nop = (dec == bank_state_pkg::CMD_DESELECT) || (dec == bank_state_pkg::CMD_NOP);

    // Clock enable history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cke_prev_q <= 1'b1;
        end else begin
            cke_prev_q <= cke;
        end
    end

    // Banks move only with both samples high
    assign normal = cke_prev_q && cke && (pwr_state_q == bank_state_pkg::PW_NORMAL);
    assign hold = !(cke_prev_q && cke);

    // Bank state summaries before this edge
    always_comb begin
        any_open = 1'b0;
        all_idle = 1'b1;
        for (int i = 0; i < `NUM_BANKS; i++) begin
            if (bank_state_q[i] != bank_state_pkg::BK_IDLE) begin
                all_idle = 1'b0;
            end
            if (bank_state_q[i] != bank_state_pkg::BK_IDLE
                && bank_state_q[i] != bank_state_pkg::BK_PRECHARGING) begin
                any_open = 1'b1;
            end
        end
    end

    assign any_burst = |busy;

    // Per-bank request steering
    always_comb begin
        for (int i = 0; i < `NUM_BANKS; i++) begin
            logic hit;
            logic col;
            hit = normal && (cmd.bank == `BANK_BITS'(i));
            col = normal && (dec == bank_state_pkg::CMD_READ || dec == bank_state_pkg::CMD_WRITE);
            req[i] = '0;
            req[i].activate = hit && dec == bank_state_pkg::CMD_ACTIVE;
            req[i].read = hit && dec == bank_state_pkg::CMD_READ;
            req[i].write = hit && dec == bank_state_pkg::CMD_WRITE;
            req[i].auto_pre = cmd.ap;
            // Precharge all reaches every bank
            req[i].precharge = normal && dec == bank_state_pkg::CMD_PRECHARGE
                               && (cmd.ap || cmd.bank == `BANK_BITS'(i));
            // Stop reaches only the bank whose burst was issued last
            req[i].stop = normal && dec == bank_state_pkg::CMD_BURST_STOP
                          && last_burst_q == `BANK_BITS'(i);
            // A column command elsewhere cuts this bank's burst
            req[i].interrupt = col && !hit && busy[i]
                               && last_burst_q == `BANK_BITS'(i);
        end
    end

    // Bank of the current burst
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_burst_q <= '0;
        end else if (normal && (dec == bank_state_pkg::CMD_READ
                                || dec == bank_state_pkg::CMD_WRITE)) begin
            last_burst_q <= cmd.bank;
        end
    end

    // One state machine per bank
    genvar g;
    generate
        for (g = 0; g < `NUM_BANKS; g++) begin : g_bank
            bank_fsm u_bank (
                .core_clk(core_clk),
                .rst(rst),
                .hold(hold),
                .req(req[g]),
                .state_q(bank_state_q[g]),
                .busy_q(busy[g])
            );
        end
    endgenerate

    // Global power state from the clock enable pair
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr_state_q <= bank_state_pkg::PW_NORMAL;
            gcnt_q <= '0;
        end else begin
            if (gcnt_q != '0) begin
                gcnt_q <= gcnt_q - 1'b1;
            end
            case (pwr_state_q)
                bank_state_pkg::PW_NORMAL: begin
                    if (cke_prev_q && !cke) begin
                        if (any_burst) begin
                            pwr_state_q <= bank_state_pkg::PW_CLOCK_SUSPEND;
                        end else if (all_idle && nop) begin
                            pwr_state_q <= bank_state_pkg::PW_PRECHARGE_PD;
                        end else if (any_open && nop) begin
                            pwr_state_q <= bank_state_pkg::PW_ACTIVE_PD;
                        end else if (all_idle && dec == bank_state_pkg::CMD_REFRESH) begin
                            pwr_state_q <= bank_state_pkg::PW_SELF_REFRESH;
                        end else if (all_idle && dec == bank_state_pkg::CMD_BURST_STOP) begin
                            pwr_state_q <= bank_state_pkg::PW_DEEP_PD;
                        end
                    end else if (normal && all_idle) begin
                        // Global commands only with all banks idle
                        if (dec == bank_state_pkg::CMD_REFRESH) begin
                            pwr_state_q <= bank_state_pkg::PW_REFRESHING;
                            gcnt_q <= `CNT_W'(`T_RC_CYC - 1);
                        end else if (dec == bank_state_pkg::CMD_MODE_SET) begin
                            pwr_state_q <= bank_state_pkg::PW_MODE_SET;
                            gcnt_q <= `CNT_W'(`T_MRD_CYC - 1);
                        end
                    end
                end
                bank_state_pkg::PW_REFRESHING, bank_state_pkg::PW_MODE_SET,
                bank_state_pkg::PW_SR_RECOVERY: begin
                    // Self refresh recovery blocks commands for tRC
                    if (gcnt_q <= `CNT_W'(1)) begin
                        pwr_state_q <= bank_state_pkg::PW_NORMAL;
                    end
                end
                bank_state_pkg::PW_PRECHARGE_PD, bank_state_pkg::PW_ACTIVE_PD: begin
                    if (!cke_prev_q && cke && nop) begin
                        pwr_state_q <= bank_state_pkg::PW_NORMAL;
                    end
                end
                bank_state_pkg::PW_SELF_REFRESH: begin
                    if (!cke_prev_q && cke && nop) begin
                        pwr_state_q <= bank_state_pkg::PW_SR_RECOVERY;
                        gcnt_q <= `CNT_W'(`T_RC_CYC - 1);
                    end
                end
                bank_state_pkg::PW_CLOCK_SUSPEND, bank_state_pkg::PW_DEEP_PD: begin
                    // Exit on rising pair, any command
                    if (!cke_prev_q && cke) begin
                        pwr_state_q <= bank_state_pkg::PW_NORMAL;
                    end
                end
                default: begin
                    pwr_state_q <= bank_state_pkg::PW_NORMAL;
                end
            endcase
        end
    end

    // Sticky loss flag; host reinitialises
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_lost_q <= 1'b0;
        end else if (pwr_state_q == bank_state_pkg::PW_DEEP_PD) begin
            data_lost_q <= 1'b1;
        end
    end

    // Status flags for observation
    always_ff @(posedge core_clk) begin
        if (rst) begin
            all_idle_q <= 1'b1;
            cmd_ignored_q <= 1'b0;
        end else begin
            all_idle_q <= all_idle;
            // Command dropped while not accepting
            cmd_ignored_q <= !nop && !normal;
        end
    end

endmodule
`default_nettype wire

// file: design/bank_state_consts.svh
// Timing counts and encodings for the bank and clock-enable state logic
`ifndef BANK_STATE_CONSTS_SVH
`define BANK_STATE_CONSTS_SVH

`define NUM_BANKS 4
`define BANK_BITS 2
`define CLK_PERIOD_NS 10
// Times in ns; cycle counts rounded up
`define T_RCD_NS 20
`define T_RP_NS 20
`define T_RC_NS 70
`define T_MRD_CYC 2
`define BURST_LEN 4
`define CNT_W 4
`define T_RCD_CYC ((`T_RCD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RC_CYC ((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Address bit that selects auto precharge / precharge all
`define AP_BIT 10

`endif

// file: design/bank_state_pkg.sv
// Types shared by the bank and clock-enable state logic
package bank_state_pkg;

    typedef enum logic [3:0] {
        CMD_DESELECT,
        CMD_NOP,
        CMD_ACTIVE,
        CMD_READ,
        CMD_WRITE,
        CMD_PRECHARGE,
        CMD_REFRESH,
        CMD_MODE_SET,
        CMD_BURST_STOP
    } cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE,
        BK_ACTIVATING,
        BK_ACTIVE,
        BK_READ,
        BK_WRITE,
        BK_READ_AP,
        BK_WRITE_AP,
        BK_PRECHARGING
    } bank_st_t;

    typedef enum logic [3:0] {
        PW_NORMAL,
        PW_REFRESHING,
        PW_MODE_SET,
        PW_PRECHARGE_PD,
        PW_ACTIVE_PD,
        PW_SELF_REFRESH,
        PW_SR_RECOVERY,
        PW_CLOCK_SUSPEND,
        PW_DEEP_PD
    } pwr_st_t;

    // Command pins as sampled at one edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic ap;
    } cmd_pins_t;

    // Per-bank request from the global decoder
    typedef struct packed {
        logic activate;
        logic read;
        logic write;
        logic auto_pre;
        logic precharge;
        logic stop;
        logic interrupt;
    } bank_req_t;

endpackage

// file: design/bank_fsm.sv
// One SDRAM bank state machine with its own timing counter
`timescale 1ns/1ns
`default_nettype none
`include "bank_state_consts.svh"

module bank_fsm (
    input wire logic core_clk, // Device clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic hold, // Clock enable pair freezes the bank
    input wire bank_state_pkg::bank_req_t req, // Decoded request for this bank
    output bank_state_pkg::bank_st_t state_q, // Current bank state
    output logic busy_q // Burst data transfer in progress
);

    logic [`CNT_W-1:0] cnt_q;
    logic [`CNT_W-1:0] burst_q;

    // State and delay counters; frozen while held
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= bank_state_pkg::BK_IDLE;
            cnt_q <= '0;
            burst_q <= '0;
        end else if (!hold) begin
            if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
            if (burst_q != '0) begin
                burst_q <= burst_q - 1'b1;
            end
            case (state_q)
                bank_state_pkg::BK_IDLE: begin
                    if (req.activate) begin
                        state_q <= bank_state_pkg::BK_ACTIVATING;
                        cnt_q <= `CNT_W'(`T_RCD_CYC - 1);
                    end
                end
                bank_state_pkg::BK_ACTIVATING: begin
                    // Active once tRCD ran out
                    if (cnt_q <= `CNT_W'(1)) begin
                        state_q <= bank_state_pkg::BK_ACTIVE;
                    end
                end
                bank_state_pkg::BK_ACTIVE, bank_state_pkg::BK_READ,
                bank_state_pkg::BK_WRITE: begin
                    if (req.precharge) begin
                        state_q <= bank_state_pkg::BK_PRECHARGING;
                        cnt_q <= `CNT_W'(`T_RP_CYC - 1);
                        burst_q <= '0;
                    end else if (req.read || req.write) begin
                        if (req.auto_pre) begin
                            state_q <= req.read ? bank_state_pkg::BK_READ_AP
                                                : bank_state_pkg::BK_WRITE_AP;
                        end else begin
                            state_q <= req.read ? bank_state_pkg::BK_READ
                                                : bank_state_pkg::BK_WRITE;
                        end
                        burst_q <= `CNT_W'(`BURST_LEN - 1);
                    end else if (req.stop || req.interrupt) begin
                        state_q <= bank_state_pkg::BK_ACTIVE;
                        burst_q <= '0;
                    end else if (state_q != bank_state_pkg::BK_ACTIVE
                                 && burst_q <= `CNT_W'(1)) begin
                        state_q <= bank_state_pkg::BK_ACTIVE;
                    end
                end
                bank_state_pkg::BK_READ_AP, bank_state_pkg::BK_WRITE_AP: begin
                    // Interrupted or finished burst starts its precharge
                    if (req.interrupt || burst_q <= `CNT_W'(1)) begin
                        state_q <= bank_state_pkg::BK_PRECHARGING;
                        cnt_q <= `CNT_W'(`T_RP_CYC - 1);
                        burst_q <= '0;
                    end
                end
                bank_state_pkg::BK_PRECHARGING: begin
                    if (cnt_q <= `CNT_W'(1)) begin
                        state_q <= bank_state_pkg::BK_IDLE;
                    end
                end
                default: begin
                    state_q <= bank_state_pkg::BK_IDLE;
                end
            endcase
        end
    end

    // Burst in flight, for clock suspend
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
        end else if (!hold) begin
            busy_q <= (state_q == bank_state_pkg::BK_IDLE) ? 1'b0
                    : ((req.read || req.write)
                       || (busy_q && burst_q > `CNT_W'(1)
                           && !req.stop && !req.interrupt && !req.precharge));
        end
    end

endmodule
`default_nettype wire

// file: testbench/sdram_bank_cke_state_props.sv
// Concurrent checks on the bank and clock-enable state logic ports
`timescale 1ns/1ns
`default_nettype none
`include "bank_state_consts.svh"

module sdram_bank_cke_state_props (
    input wire logic core_clk, // Device clock
    input wire logic rst, // Sync reset
    input wire logic cke, // Clock enable
    input wire bank_state_pkg::cmd_pins_t cmd, // Command pins
    input wire bank_state_pkg::pwr_st_t pwr_state_q, // Power state
    input wire bank_state_pkg::bank_st_t bank_state_q [`NUM_BANKS], // Bank states
    input wire logic all_idle_q, // All banks idle
    input wire logic data_lost_q, // Contents lost
    input wire logic cmd_ignored_q // Command refused
);
    logic [3:0] op;
    logic idle4;
    logic normal;

    // Strobes cs, ras, cas, we
    assign op = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
    assign idle4 = bank_state_q[0] == bank_state_pkg::BK_IDLE &&
        bank_state_q[1] == bank_state_pkg::BK_IDLE &&
        bank_state_q[2] == bank_state_pkg::BK_IDLE &&
        bank_state_q[3] == bank_state_pkg::BK_IDLE;
    assign normal = pwr_state_q == bank_state_pkg::PW_NORMAL;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Entry from all idle on falling clock enable
    property p_enter(logic [3:0] c, bank_state_pkg::pwr_st_t s);
        $past(cke) && !cke && normal && idle4 && op == c |=> pwr_state_q == s;
    endproperty

    AST_ACT_DECODE: assert property ($past(cke) && cke && normal && op == 4'h3 &&
        cmd.bank == 2'h0 && bank_state_q[0] == bank_state_pkg::BK_IDLE
        |=> bank_state_q[0] == bank_state_pkg::BK_ACTIVATING)
        else $error("activate did not open bank 0");
    AST_RCD_LEN: assert property ((bank_state_q[0] == bank_state_pkg::BK_ACTIVATING &&
        cke) [*2] ##1 cke |-> bank_state_q[0] != bank_state_pkg::BK_ACTIVATING)
        else $error("row activation lasted too long");
    AST_PRE_DECODE: assert property ($past(cke) && cke && normal && op == 4'h2 &&
        (cmd.ap || cmd.bank == 2'h2) && bank_state_q[2] == bank_state_pkg::BK_ACTIVE
        |=> bank_state_q[2] == bank_state_pkg::BK_PRECHARGING)
        else $error("precharge did not close bank 2");
    AST_ENTER_PPD: assert property (p_enter(4'h7, bank_state_pkg::PW_PRECHARGE_PD))
        else $error("precharge power down not entered");
    AST_ENTER_SR: assert property (p_enter(4'h1, bank_state_pkg::PW_SELF_REFRESH))
        else $error("self refresh not entered");
    AST_ENTER_DPD: assert property (p_enter(4'h6, bank_state_pkg::PW_DEEP_PD))
        else $error("deep power down not entered");
    AST_LOW_HOLD: assert property (!cke [*4] ##0 pwr_state_q inside {
        bank_state_pkg::PW_PRECHARGE_PD, bank_state_pkg::PW_ACTIVE_PD,
        bank_state_pkg::PW_SELF_REFRESH, bank_state_pkg::PW_CLOCK_SUSPEND,
        bank_state_pkg::PW_DEEP_PD} |-> $stable(pwr_state_q))
        else $error("low-power state left with clock enable low");
    AST_FROZEN: assert property (!cke [*2] |=> $stable(bank_state_q[2]))
        else $error("bank moved while clock enable low");
    AST_IGNORED: assert property (!$past(cke) && !cke && !op[3] && op != 4'h7
        |-> ##[1:2] cmd_ignored_q)
        else $error("command not flagged as ignored");
    AST_IDLE_FLAG: assert property (all_idle_q == $past(idle4))
        else $error("idle flag does not follow bank states");
    AST_LOST: assert property (pwr_state_q == bank_state_pkg::PW_DEEP_PD
        |-> ##[0:1] data_lost_q)
        else $error("deep power down without loss flag");
    AST_SUSP_EXIT: assert property (pwr_state_q == bank_state_pkg::PW_CLOCK_SUSPEND &&
        cke && !$past(cke) |-> ##[1:2] pwr_state_q != bank_state_pkg::PW_CLOCK_SUSPEND)
        else $error("clock suspend not left");

    // Main scenarios reached
    cover property (pwr_state_q == bank_state_pkg::PW_SELF_REFRESH);
    cover property (pwr_state_q == bank_state_pkg::PW_CLOCK_SUSPEND);
    cover property (bank_state_q[0] == bank_state_pkg::BK_READ_AP ##1
        bank_state_q[0] == bank_state_pkg::BK_PRECHARGING);
endmodule

bind sdram_bank_cke_state sdram_bank_cke_state_props sdram_bank_cke_state_props_i (
    .core_clk(core_clk), .rst(rst), .cke(cke), .cmd(cmd), .pwr_state_q(pwr_state_q),
    .bank_state_q(bank_state_q), .all_idle_q(all_idle_q), .data_lost_q(data_lost_q),
    .cmd_ignored_q(cmd_ignored_q));
`default_nettype wire

// file: testbench/ctrl_model.sv
// Controller-side model that puts requested commands on the pins
`timescale 1ns/1ns
`default_nettype none

module ctrl_model (
    input wire logic core_clk, // Device clock
    input wire logic rst, // Sync reset
    input wire bank_state_pkg::cmd_t op, // Requested command
    input wire logic [1:0] bank, // Target bank
    input wire logic ap, // Auto precharge or all banks
    input wire logic all_idle, // Device reports all banks idle
    output bank_state_pkg::cmd_pins_t pins // Pins to the device
);
    logic [2:0] last_q;
    logic [3:0] enc;

    // Listed encodings only
    always_comb begin
        case (op)
            bank_state_pkg::CMD_NOP: enc = 4'h7;
            bank_state_pkg::CMD_ACTIVE: enc = 4'h3;
            bank_state_pkg::CMD_READ: enc = 4'h5;
            bank_state_pkg::CMD_WRITE: enc = 4'h4;
            bank_state_pkg::CMD_PRECHARGE: enc = 4'h2;
            bank_state_pkg::CMD_REFRESH: enc = all_idle ? 4'h1 : 4'h7;
            bank_state_pkg::CMD_MODE_SET: enc = all_idle ? 4'h0 : 4'h7;
            bank_state_pkg::CMD_BURST_STOP: enc = 4'h6;
            default: enc = {1'b1, ~last_q};
        endcase
    end

    // Last strobes, inverted on deselect so nothing settles by luck
    always_ff @(posedge core_clk) begin
        last_q <= rst ? 3'h7 : enc[2:0];
    end

    assign pins = {enc, bank, ap};
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the bank and clock-enable state logic
`timescale 1ns/1ns
`default_nettype none
`include "bank_state_consts.svh"

module testbench;
    typedef struct {
        bank_state_pkg::cmd_t op;
        logic [1:0] bk;
        logic ap;
        int bi;
        bank_state_pkg::bank_st_t eb;
        int lim;
    } row_t;
    logic core_clk;
    logic rst;
    logic cke;
    logic [1:0] bk;
    logic ap;
    bank_state_pkg::cmd_t op;
    bank_state_pkg::cmd_pins_t pins;
    bank_state_pkg::pwr_st_t pwr_state_q;
    bank_state_pkg::bank_st_t bank_state_q [`NUM_BANKS];
    logic all_idle_q;
    logic data_lost_q;
    logic cmd_ignored_q;
    int errors;
    int compares;
    row_t rows [10];

    sdram_bank_cke_state sdram_bank_cke_state_i (.core_clk(core_clk), .rst(rst), .cke(cke),
        .cmd(pins), .pwr_state_q(pwr_state_q), .bank_state_q(bank_state_q),
        .all_idle_q(all_idle_q), .data_lost_q(data_lost_q), .cmd_ignored_q(cmd_ignored_q));
    ctrl_model ctrl_model_i (.core_clk(core_clk), .rst(rst), .op(op), .bank(bk), .ap(ap),
        .all_idle(all_idle_q), .pins(pins));

    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Bounded run; a hang counts as a mismatch
    initial begin
        #20000;
        errors++;
        give_verdict();
    end

    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // 0..3 bank, 4 power, 5 ignored, 6 lost
    function automatic logic [7:0] cur(input int bi);
        case (bi)
            4: return 8'(pwr_state_q);
            5: return {7'h00, cmd_ignored_q};
            6: return {7'h00, data_lost_q};
            default: return 8'(bank_state_q[bi]);
        endcase
    endfunction

    // One command for one cycle, clock enable left at c
    task automatic send(input bank_state_pkg::cmd_t o, input logic [1:0] b, input logic a,
        input logic c);
        @(posedge core_clk);
        op <= o;
        bk <= b;
        ap <= a;
        cke <= c;
        @(posedge core_clk);
        op <= bank_state_pkg::CMD_NOP;
    endtask

    // No-op for one cycle with clock enable at c
    task automatic nop_at(input logic c);
        send(bank_state_pkg::CMD_NOP, 2'h0, 1'b0, c);
    endtask

    // Bounded wait, then compare
    task automatic wait_for(input int bi, input logic [7:0] e, input int lim);
        int n = 0;
        #1;
        while (n < lim && cur(bi) !== e) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check(cur(bi), e);
    endtask

    initial begin
        errors = 0;
        compares = 0;
        rst = 1'b1;
        cke = 1'b1;
        op = bank_state_pkg::CMD_NOP;
        bk = 2'h0;
        ap = 1'b0;
        rows[0] = '{bank_state_pkg::CMD_ACTIVE, 2'h0, 1'b0, 0, bank_state_pkg::BK_ACTIVE, 6};
        rows[1] = '{bank_state_pkg::CMD_ACTIVE, 2'h1, 1'b0, 1, bank_state_pkg::BK_ACTIVE, 6};
        rows[2] = '{bank_state_pkg::CMD_READ, 2'h0, 1'b1, 0, bank_state_pkg::BK_READ_AP, 2};
        rows[3] = '{bank_state_pkg::CMD_READ, 2'h1, 1'b0, 0, bank_state_pkg::BK_PRECHARGING, 2};
        rows[4] = '{bank_state_pkg::CMD_BURST_STOP, 2'h0, 1'b0, 1, bank_state_pkg::BK_ACTIVE, 2};
        rows[5] = '{bank_state_pkg::CMD_DESELECT, 2'h0, 1'b0, 0, bank_state_pkg::BK_IDLE, 6};
        rows[6] = '{bank_state_pkg::CMD_WRITE, 2'h1, 1'b0, 1, bank_state_pkg::BK_WRITE, 2};
        rows[7] = '{bank_state_pkg::CMD_NOP, 2'h0, 1'b0, 1, bank_state_pkg::BK_ACTIVE, 6};
        rows[8] = '{bank_state_pkg::CMD_PRECHARGE, 2'h1, 1'b0, 1,
            bank_state_pkg::BK_PRECHARGING, 2};
        rows[9] = '{bank_state_pkg::CMD_DESELECT, 2'h0, 1'b0, 1, bank_state_pkg::BK_IDLE, 6};
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 0);
        check({5'h00, all_idle_q, data_lost_q, cmd_ignored_q}, 8'h04);
        $display("Test reset done");
        // Cross-bank table
        foreach (rows[i]) begin
            send(rows[i].op, rows[i].bk, rows[i].ap, 1'b1);
            wait_for(rows[i].bi, 8'(rows[i].eb),
                rows[i].lim);
        end
        send(bank_state_pkg::CMD_REFRESH, 2'h0, 1'b0, 1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_REFRESHING), 2);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 9);
        $display("Test bank table done");
        // Power down ignores commands
        nop_at(1'b0);
        wait_for(4, 8'(bank_state_pkg::PW_PRECHARGE_PD), 2);
        send(bank_state_pkg::CMD_ACTIVE, 2'h0, 1'b0, 1'b0);
        wait_for(5, 8'h01, 2);
        wait_for(4, 8'(bank_state_pkg::PW_PRECHARGE_PD), 0);
        wait_for(0, 8'(bank_state_pkg::BK_IDLE), 0);
        nop_at(1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 2);
        send(bank_state_pkg::CMD_ACTIVE, 2'h2, 1'b0, 1'b1);
        wait_for(2, 8'(bank_state_pkg::BK_ACTIVE), 6);
        nop_at(1'b0);
        wait_for(4, 8'(bank_state_pkg::PW_ACTIVE_PD), 2);
        nop_at(1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 2);
        // Clock suspend in mid burst
        send(bank_state_pkg::CMD_READ, 2'h2, 1'b0, 1'b1);
        nop_at(1'b0);
        wait_for(4, 8'(bank_state_pkg::PW_CLOCK_SUSPEND), 2);
        repeat (3) @(posedge core_clk);
        wait_for(2, 8'(bank_state_pkg::BK_READ), 0);
        nop_at(1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 2);
        wait_for(2, 8'(bank_state_pkg::BK_ACTIVE), 6);
        send(bank_state_pkg::CMD_PRECHARGE, 2'h0, 1'b1, 1'b1);
        wait_for(2, 8'(bank_state_pkg::BK_IDLE), 6);
        $display("Test power down and suspend done");
        send(bank_state_pkg::CMD_REFRESH, 2'h0, 1'b0, 1'b0);
        wait_for(4, 8'(bank_state_pkg::PW_SELF_REFRESH), 2);
        nop_at(1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_SR_RECOVERY), 2);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 10);
        send(bank_state_pkg::CMD_BURST_STOP, 2'h0, 1'b0, 1'b0);
        wait_for(4, 8'(bank_state_pkg::PW_DEEP_PD), 2);
        wait_for(6, 8'h01, 2);
        nop_at(1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 2);
        wait_for(6, 8'h01, 0);
        // Second reset, then start-up
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        wait_for(6, 8'h00, 0);
        send(bank_state_pkg::CMD_MODE_SET, 2'h0, 1'b0, 1'b1);
        wait_for(4, 8'(bank_state_pkg::PW_MODE_SET), 2);
        wait_for(4, 8'(bank_state_pkg::PW_NORMAL), 4);
        $display("Test refresh and deep power down done");
        give_verdict();
    end
endmodule
`default_nettype wire
